// [design/ism_pkg.sv]
// Constants for the mirrored interrupt status register.
// Assumes a register access path elsewhere supplies 8-bit addresses.
package ism_pkg;
	localparam int             ISM_DATA_W        = 8;
	localparam int             ISM_ADDR_W        = 8;
	localparam logic [7:0]     ISM_MIRROR_OFFSET = 8'h4c;
	localparam logic [7:0]     ISM_MIRROR_RESET  = 8'h00;
	localparam logic [7:0]     ISM_RDATA_IDLE    = 8'h00;
	localparam int             ISM_BIT_INT_TEMP  = 0;
	localparam int             ISM_BIT_REM_TWO   = 1;
	localparam int             ISM_BIT_DIODE_TWO = 2;
	localparam int             ISM_BIT_RESERVED  = 3;
	localparam int             ISM_BIT_GEN_INPUT = 4;
	localparam int             ISM_BIT_REM_ONE   = 5;
	localparam int             ISM_BIT_THERMAL_OVERLOAD_LINE     = 6;
	localparam int             ISM_BIT_DIODE_ONE = 7;
	localparam logic           ISM_RESERVED_VAL  = 1'b0;

	typedef enum logic [1:0] {
		ISM_ACC_NONE,
		ISM_ACC_READ,
		ISM_ACC_WRITE
	} ism_access_t;
endpackage : ism_pkg

// [design/ism_flag_cell.sv]
// One status bit storage cell with synchronous clear.
// Assumes a single clock and an active low synchronous reset.
`timescale 1ns/100ps
module ism_flag_cell #(
	parameter int            WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             core_clk_in,
	input  wire logic             resetn_in,
	input  wire logic [WIDTH-1:0] flag_next_in,
	output logic      [WIDTH-1:0] flag_reg_out
);
	always_ff @(posedge core_clk_in)
	begin
		if (!resetn_in)
			flag_reg_out <= RESET_VAL;
		else
			flag_reg_out <= flag_next_in;
	end
endmodule : ism_flag_cell

// [design/ism_read_port.sv]
// Registered read port for one read-only register.
// Assumes read and write strobes are one-cycle pulses, never both at once.
`timescale 1ns/100ps
module ism_read_port
#(
	parameter int                   DATA_W = ism_pkg::ISM_DATA_W,
	parameter int                   ADDR_W = ism_pkg::ISM_ADDR_W,
	parameter logic [ADDR_W-1:0]    OFFSET = ism_pkg::ISM_MIRROR_OFFSET
) (
	input  wire logic              core_clk_in,
	input  wire logic              resetn_in,
	input  wire logic [ADDR_W-1:0] reg_addr_in,
	input  wire logic              reg_rd_in,
	input  wire logic [DATA_W-1:0] value_in,
	output logic      [DATA_W-1:0] reg_rdata_out,
	output logic                   reg_rvalid_out
);
	import ism_pkg::*;

	logic hit;

	assign hit = reg_rd_in && (reg_addr_in == OFFSET);

	// Unmapped reads answer with zero data so the bus never sees stale bits
	always_ff @(posedge core_clk_in)
	begin
		if (!resetn_in)
		begin
			reg_rdata_out  <= ISM_RDATA_IDLE;
			reg_rvalid_out <= 1'b0;
		end
		else
		begin
			reg_rdata_out  <= hit ? value_in : ISM_RDATA_IDLE;
			reg_rvalid_out <= reg_rd_in;
		end
	end
endmodule : ism_read_port

// [design/ism_status_mirror.sv]
// Read-only mirror of the interrupt status flags, reached by register address.
// Assumes status levels come from limit and fault logic elsewhere, all
// synchronous to core_clk_in, and that the polarity control comes from the
// configuration register.
`timescale 1ns/100ps
module ism_status_mirror
(
	input  wire logic                           core_clk_in,
	input  wire logic                           resetn_in,
	input  wire logic                           int_temp_limit_in,
	input  wire logic                           remote_one_limit_flag_in,
	input  wire logic                           remote_two_limit_flag_in,
	input  wire logic                           diode_one_fault_in,
	input  wire logic                           diode_two_fault_in,
	input  wire logic                           general_input_pin_in,
	input  wire logic                           input_polarity_flip_in,
	input  wire logic                           thermal_overload_line_n_in,
	input  wire logic                           thermal_overload_line_self_drive_in,
	input  wire logic [ism_pkg::ISM_ADDR_W-1:0] reg_addr_in,
	input  wire logic                           reg_rd_in,
	input  wire logic                           reg_wr_in,
	input  wire logic [ism_pkg::ISM_DATA_W-1:0] reg_wdata_in,
	output logic      [ism_pkg::ISM_DATA_W-1:0] reg_rdata_out,
	output logic                                reg_rvalid_out,
	output logic      [ism_pkg::ISM_DATA_W-1:0] mirror_out
);
	import ism_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Access classification

	ism_access_t               access;
	logic                      thermal_overload_line_external;
	logic [ISM_DATA_W-1:0]     mirror_next;
	logic [ISM_DATA_W-1:0]     mirror_reg;
	logic                      past_valid_reg;

	always_comb
	begin
		case ({reg_rd_in, reg_wr_in})
			2'b10:   access = ISM_ACC_READ;
			2'b01:   access = ISM_ACC_WRITE;
			default: access = ISM_ACC_NONE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next value of every mirrored bit

	// The line is shared; our own drive must not count as an external assertion
	assign thermal_overload_line_external = !thermal_overload_line_n_in && !thermal_overload_line_self_drive_in;

	// Write data and strobes deliberately reach nothing here
	always_comb
	begin
		mirror_next                    = ISM_MIRROR_RESET;
		mirror_next[ISM_BIT_INT_TEMP]  = int_temp_limit_in;
		mirror_next[ISM_BIT_REM_TWO]   = remote_two_limit_flag_in;
		mirror_next[ISM_BIT_DIODE_TWO] = diode_two_fault_in;
		mirror_next[ISM_BIT_RESERVED]  = ISM_RESERVED_VAL;
		// Pin level XOR the polarity control, so a read cannot clear it and no history is held
		mirror_next[ISM_BIT_GEN_INPUT] = general_input_pin_in ^ input_polarity_flip_in;
		mirror_next[ISM_BIT_REM_ONE]   = remote_one_limit_flag_in;
		mirror_next[ISM_BIT_THERMAL_OVERLOAD_LINE]     = thermal_overload_line_external;
		mirror_next[ISM_BIT_DIODE_ONE] = diode_one_fault_in;
	end

	////////////////////////////////////////////////////////////////////////////
	// Storage, one cell per bit

	genvar gi;
	generate
		for (gi = 0; gi < ISM_DATA_W; gi++)
		begin : g_cell
			ism_flag_cell #(
				.WIDTH     (1),
				.RESET_VAL (ISM_MIRROR_RESET[gi])
			) u_cell (
				.core_clk_in  (core_clk_in),
				.resetn_in    (resetn_in),
				.flag_next_in (mirror_next[gi]),
				.flag_reg_out (mirror_reg[gi])
			);
		end
	endgenerate

	assign mirror_out = mirror_reg;

	////////////////////////////////////////////////////////////////////////////
	// Register read path

	ism_read_port #(
		.DATA_W (ISM_DATA_W),
		.ADDR_W (ISM_ADDR_W),
		.OFFSET (ISM_MIRROR_OFFSET)
	) u_read (
		.core_clk_in    (core_clk_in),
		.resetn_in      (resetn_in),
		.reg_addr_in    (reg_addr_in),
		.reg_rd_in      (access == ISM_ACC_READ),
		.value_in       (mirror_reg),
		.reg_rdata_out  (reg_rdata_out),
		.reg_rvalid_out (reg_rvalid_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks

	always_ff @(posedge core_clk_in)
	begin
		if (!resetn_in)
			past_valid_reg <= 1'b0;
		else
			past_valid_reg <= 1'b1;
	end

	a_reset_clears_all: assert property (
		@(posedge core_clk_in) $rose(resetn_in) |-> mirror_reg == ISM_MIRROR_RESET)
		else $error("mirror not zero after reset");

	a_int_temp_copy: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg |-> mirror_reg[ISM_BIT_INT_TEMP] == $past(int_temp_limit_in))
		else $error("bit 0 does not follow internal limit flag");

	a_remote_two_copy: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg |-> mirror_reg[ISM_BIT_REM_TWO] == $past(remote_two_limit_flag_in))
		else $error("bit 1 does not follow remote two limit");

	a_diode_two_copy: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg |-> mirror_reg[ISM_BIT_DIODE_TWO] == $past(diode_two_fault_in))
		else $error("bit 2 does not follow diode two fault");

	a_input_polarity: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg |-> mirror_reg[ISM_BIT_GEN_INPUT] ==
			($past(general_input_pin_in) ^ $past(input_polarity_flip_in)))
		else $error("bit 4 polarity wrong");

	a_input_not_latched: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg && !general_input_pin_in && !input_polarity_flip_in
		|=> !mirror_reg[ISM_BIT_GEN_INPUT])
		else $error("bit 4 held a past assertion");

	a_read_keeps_input: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		reg_rd_in && !reg_wr_in && mirror_reg[ISM_BIT_GEN_INPUT]
		&& $stable(general_input_pin_in) && $stable(input_polarity_flip_in)
		|=> mirror_reg[ISM_BIT_GEN_INPUT] && reg_rdata_out[ISM_BIT_GEN_INPUT]
			== ($past(reg_addr_in) == ISM_MIRROR_OFFSET))
		else $error("read disturbed bit 4");

	a_remote_one_copy: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg |-> mirror_reg[ISM_BIT_REM_ONE] == $past(remote_one_limit_flag_in))
		else $error("bit 5 does not follow remote one limit");

	a_thermal_overload_line_external: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg |-> mirror_reg[ISM_BIT_THERMAL_OVERLOAD_LINE] ==
			(!$past(thermal_overload_line_n_in) && !$past(thermal_overload_line_self_drive_in)))
		else $error("bit 6 wrong for overload line");

	a_diode_one_copy: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg |-> mirror_reg[ISM_BIT_DIODE_ONE] == $past(diode_one_fault_in))
		else $error("bit 7 does not follow diode one fault");

	a_write_ignored: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		reg_wr_in && $stable(mirror_next) && past_valid_reg
		|=> $stable(mirror_reg) && !mirror_reg[ISM_BIT_RESERVED])
		else $error("write changed the mirror");

	a_read_answer: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		reg_rd_in && !reg_wr_in && reg_addr_in == ISM_MIRROR_OFFSET
		|=> reg_rvalid_out && reg_rdata_out == $past(mirror_reg))
		else $error("read answer wrong");

	a_reserved_fixed: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg
		|-> mirror_reg[ISM_BIT_RESERVED] == ISM_RESERVED_VAL)
		else $error("reserved bit 3 moved");

	a_input_follows_pin: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg && general_input_pin_in && !input_polarity_flip_in
		|=> mirror_reg[ISM_BIT_GEN_INPUT])
		else $error("bit 4 missed a high pin");

	a_inverted_low_input: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg && !general_input_pin_in && input_polarity_flip_in
		|=> mirror_reg[ISM_BIT_GEN_INPUT])
		else $error("bit 4 missed an inverted low pin");

	a_inverted_high_input: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg && general_input_pin_in && input_polarity_flip_in
		|=> !mirror_reg[ISM_BIT_GEN_INPUT])
		else $error("bit 4 set for an inverted high pin");

	a_flip_changes_sense: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg && $changed(input_polarity_flip_in)
		&& $stable(general_input_pin_in)
		|=> $changed(mirror_reg[ISM_BIT_GEN_INPUT]))
		else $error("bit 4 ignored a polarity change");

	a_thermal_overload_line_self_masked: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg && thermal_overload_line_self_drive_in
		|=> !mirror_reg[ISM_BIT_THERMAL_OVERLOAD_LINE])
		else $error("bit 6 counted our own drive");

	a_thermal_overload_line_line_idle: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg && thermal_overload_line_n_in
		|=> !mirror_reg[ISM_BIT_THERMAL_OVERLOAD_LINE])
		else $error("bit 6 set with the line idle");

	a_thermal_overload_line_line_active: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		past_valid_reg && !thermal_overload_line_n_in && !thermal_overload_line_self_drive_in
		|=> mirror_reg[ISM_BIT_THERMAL_OVERLOAD_LINE])
		else $error("bit 6 missed an external drive");

	////////////////////////////////////////////////////////////////////////////
	// Reset and read path checks

	a_reset_outputs_idle: assert property (
		@(posedge core_clk_in)
		!resetn_in
		|=> mirror_reg == ISM_MIRROR_RESET && !reg_rvalid_out
			&& reg_rdata_out == ISM_RDATA_IDLE)
		else $error("outputs not cleared by reset");

	a_release_read_idle: assert property (
		@(posedge core_clk_in)
		$rose(resetn_in)
		|-> !reg_rvalid_out && reg_rdata_out == ISM_RDATA_IDLE)
		else $error("read port busy after reset");

	a_read_gets_valid: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		reg_rd_in && !reg_wr_in
		|=> reg_rvalid_out)
		else $error("read strobe not answered");

	a_miss_reads_idle: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		reg_rd_in && !reg_wr_in && reg_addr_in != ISM_MIRROR_OFFSET
		|=> reg_rvalid_out && reg_rdata_out == ISM_RDATA_IDLE)
		else $error("unmapped read returned data");

	a_idle_bus_quiet: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		!(reg_rd_in && !reg_wr_in)
		|=> !reg_rvalid_out && reg_rdata_out == ISM_RDATA_IDLE)
		else $error("answer without a read");

	a_rvalid_from_read: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		reg_rvalid_out
		|-> $past(reg_rd_in) && !$past(reg_wr_in))
		else $error("valid pulse without a read strobe");

	a_idle_data_zero: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		!reg_rvalid_out
		|-> reg_rdata_out == ISM_RDATA_IDLE)
		else $error("read data left standing");

	a_write_no_answer: assert property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		reg_wr_in
		|=> !reg_rvalid_out)
		else $error("write strobe was answered");

	c_read_hit: cover property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		reg_rd_in && reg_addr_in == ISM_MIRROR_OFFSET ##1 reg_rdata_out != ISM_RDATA_IDLE);

	c_flip_set: cover property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		input_polarity_flip_in && !general_input_pin_in ##1 mirror_reg[ISM_BIT_GEN_INPUT]);

	c_thermal_overload_line_ext: cover property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		mirror_reg[ISM_BIT_THERMAL_OVERLOAD_LINE]);

	c_write_seen: cover property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		reg_wr_in && reg_addr_in == ISM_MIRROR_OFFSET && reg_wdata_in != mirror_reg);

	c_rd_wr_clash: cover property (
		@(posedge core_clk_in) disable iff (!resetn_in)
		reg_rd_in && reg_wr_in);
endmodule : ism_status_mirror

// [tb/ism_status_mirror_tb.sv]
// Self-checking bench for the read-only status mirror register.
// Assumes ism_pkg and the design files are compiled first.
`timescale 1ns/100ps
module testbench;
	import ism_pkg::*;

`define CHECK(got, exp) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("[FAIL] %0t got %h expected %h", $time, got, exp); \
		end \
	end

	logic                  core_clk_in;
	logic                  resetn_in;
	logic                  int_temp_limit_in;
	logic                  remote_one_limit_flag_in;
	logic                  remote_two_limit_flag_in;
	logic                  diode_one_fault_in;
	logic                  diode_two_fault_in;
	logic                  general_input_pin_in;
	logic                  input_polarity_flip_in;
	logic                  thermal_overload_line_n_in;
	logic                  thermal_overload_line_self_drive_in;
	logic [ISM_ADDR_W-1:0] reg_addr_in;
	logic                  reg_rd_in;
	logic                  reg_wr_in;
	logic [ISM_DATA_W-1:0] reg_wdata_in;
	logic [ISM_DATA_W-1:0] reg_rdata_out;
	logic                  reg_rvalid_out;
	logic [ISM_DATA_W-1:0] mirror_out;
	int                    n_fail;
	int                    num_checks;
	int                    cycles;
	int                    bit_list [7] = '{0, 1, 2, 4, 5, 6, 7};

	ism_status_mirror dut (
		.core_clk_in                (core_clk_in),
		.resetn_in                  (resetn_in),
		.int_temp_limit_in          (int_temp_limit_in),
		.remote_one_limit_flag_in   (remote_one_limit_flag_in),
		.remote_two_limit_flag_in   (remote_two_limit_flag_in),
		.diode_one_fault_in         (diode_one_fault_in),
		.diode_two_fault_in         (diode_two_fault_in),
		.general_input_pin_in       (general_input_pin_in),
		.input_polarity_flip_in     (input_polarity_flip_in),
		.thermal_overload_line_n_in (thermal_overload_line_n_in),
		.thermal_overload_line_self_drive_in        (thermal_overload_line_self_drive_in),
		.reg_addr_in                (reg_addr_in),
		.reg_rd_in                  (reg_rd_in),
		.reg_wr_in                  (reg_wr_in),
		.reg_wdata_in               (reg_wdata_in),
		.reg_rdata_out              (reg_rdata_out),
		.reg_rvalid_out             (reg_rvalid_out),
		.mirror_out                 (mirror_out)
	);

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	// Inputs change 1 ns after the edge so the sampling edge never races them
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask : tick

	// Drives the status inputs so that the mirror should read w
	task automatic apply(input logic [7:0] w);
		int_temp_limit_in          = w[0];
		remote_two_limit_flag_in   = w[1];
		diode_two_fault_in         = w[2];
		general_input_pin_in       = w[4] ^ input_polarity_flip_in;
		remote_one_limit_flag_in   = w[5];
		thermal_overload_line_n_in = ~w[6];
		diode_one_fault_in         = w[7];
	endtask : apply

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr_in = a;
		reg_rd_in   = 1'b1;
		tick(1);
		`CHECK(reg_rvalid_out, 1'b1)
		`CHECK(reg_rdata_out, exp)
		reg_rd_in   = 1'b0;
		tick(1);
	endtask : rd

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	// Whole run needs about 70 cycles; 2000 leaves ample margin
	always @(posedge core_clk_in)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_fail++;
			$display("[FAIL] %0t run did not finish", $time);
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		n_fail = 0; num_checks = 0; cycles = 0;
		resetn_in = 1'b0; input_polarity_flip_in = 1'b0; thermal_overload_line_self_drive_in = 1'b0;
		reg_addr_in = 8'h00; reg_rd_in = 1'b0; reg_wr_in = 1'b0; reg_wdata_in = 8'h00;
		apply(8'hf7);
		tick(10);
		`CHECK(mirror_out, 8'h00)
		apply(8'h00);
		resetn_in = 1'b1;
		rd(ISM_MIRROR_OFFSET, 8'h00);
		foreach (bit_list[i])
		begin
			apply(8'h01 << bit_list[i]);
			tick(1);
			`CHECK(mirror_out, 8'h01 << bit_list[i])
			rd(ISM_MIRROR_OFFSET, 8'h01 << bit_list[i]);
		end
		apply(8'hf7);
		tick(1);
		rd(ISM_MIRROR_OFFSET, 8'hf7);
		apply(8'h00);
		for (int i = 0; i < 4; i++)
		begin
			{input_polarity_flip_in, general_input_pin_in} = i[1:0];
			tick(2);
			`CHECK(mirror_out[4], i[0] ^ i[1])
		end
		input_polarity_flip_in = 1'b0;
		general_input_pin_in   = 1'b1;
		tick(1);
		rd(ISM_MIRROR_OFFSET, 8'h10);
		rd(ISM_MIRROR_OFFSET, 8'h10);
		general_input_pin_in = 1'b0;
		tick(1);
		rd(ISM_MIRROR_OFFSET, 8'h00);
		// Line low only because this chip drives it: not an external assertion
		thermal_overload_line_n_in = 1'b0;
		thermal_overload_line_self_drive_in        = 1'b1;
		tick(2);
		`CHECK(mirror_out, 8'h00)
		thermal_overload_line_self_drive_in = 1'b0;
		apply(8'ha5);
		tick(1);
		reg_addr_in  = ISM_MIRROR_OFFSET;
		reg_wdata_in = 8'h5a;
		reg_wr_in    = 1'b1;
		tick(1);
		reg_wr_in = 1'b0;
		tick(1);
		`CHECK(mirror_out, 8'ha5)
		rd(ISM_MIRROR_OFFSET, 8'ha5);
		rd(8'h4b, 8'h00);
		tick(1);
		`CHECK({reg_rvalid_out, reg_rdata_out}, 9'h000)
		reg_addr_in = ISM_MIRROR_OFFSET;
		reg_rd_in   = 1'b1;
		reg_wr_in   = 1'b1;
		tick(1);
		`CHECK({reg_rvalid_out, reg_rdata_out}, 9'h000)
		reg_rd_in = 1'b0;
		reg_wr_in = 1'b0;
		tick(1);
		apply(8'hf7);
		resetn_in = 1'b0;
		tick(2);
		`CHECK(mirror_out, 8'h00)
		resetn_in = 1'b1;
		tick(2);
		`CHECK(mirror_out, 8'hf7)
		end_of_test();
	end
endmodule : testbench
